// *** verilog/prf_pkg.sv ***
// package of constants for the per-module reset fanout
package prf_pkg;
  localparam int CORE_N       = 5;
  localparam int CORE_PERIPH  = 0;
  localparam int CORE_SAFETY  = 1;
  localparam int CORE_CHECKER = 2;
  localparam int CORE_COMPUTE = 3;
  localparam int CORE_SECURE  = 4;
  localparam int PRST_W       = 256;
  // peripheral reset bit positions
  localparam int SPI_N        = 8;
  localparam int SPI_IDX [SPI_N] = '{99, 98, 227, 226, 97, 225, 96, 93};
  localparam int TWI_N        = 2;
  localparam int TWI_IDX [TWI_N] = '{101, 229};
  localparam int PIT_N        = 2;
  localparam int PIT_IDX [PIT_N] = '{30, 31};
  localparam int LIN_N        = 6;
  localparam int LIN_IDX [LIN_N] = '{92, 91, 220, 85, 213, 84};
  localparam int PSI_N        = 3;
  localparam int PSI_IDX [PSI_N] = '{111, 239, 162};
  localparam int SENT_N       = 2;
  localparam int SENT_IDX [SENT_N] = '{104, 232};
  localparam int DMX_IDX      = 36;
  localparam int BC_N         = 2;
  localparam int BC_IDX [BC_N] = '{107, 235};
  localparam int LINK_IDX     = 11;
  localparam int TMI_IDX      = 128;
  // widths and post-reset values
  localparam int TCR_W        = 16;
  localparam int BAUD_W       = 20;
  localparam int PSI_CH_N     = 4;
  localparam int SENT_CH_N    = 8;
  localparam int DMX_CH_N     = 16;
  localparam logic [TCR_W-1:0]  TCR_RST  = 16'h0000;
  localparam logic [BAUD_W-1:0] BAUD_RST = 20'h0_0000;
  localparam logic              LIN_TX_RECESSIVE = 1'b1;
endpackage : prf_pkg

// *** verilog/prf_fanout.sv ***
// per-module reset fanout with post-reset control state of each receiving unit
`timescale 1ns/1ps
module prf_fanout (
  input  wire logic                               clock_i,
  input  wire logic                               rst_n_i,
  input  wire logic [prf_pkg::CORE_N-1:0]         core_reset_vector_i,
  input  wire logic [prf_pkg::PRST_W-1:0]         peripheral_reset_bits_i,
  output logic      [prf_pkg::CORE_N-1:0]         core_reset_o,
  output logic                                    lockstep_compare_event_o,
  // serial peripheral ports
  input  wire logic [prf_pkg::SPI_N-1:0]          spi_disable_wr_i,
  input  wire logic [prf_pkg::SPI_N-1:0]          spi_disable_val_i,
  input  wire logic [prf_pkg::SPI_N-1:0]          spi_halt_wr_i,
  input  wire logic [prf_pkg::SPI_N-1:0]          spi_halt_val_i,
  input  wire logic [prf_pkg::SPI_N-1:0]          spi_frame_done_i,
  output logic      [prf_pkg::SPI_N-1:0]          spi_module_disable_o,
  output logic      [prf_pkg::SPI_N-1:0]          spi_halt_o,
  output logic      [prf_pkg::SPI_N-1:0]          spi_run_o,
  output logic      [prf_pkg::SPI_N*prf_pkg::TCR_W-1:0] transfer_count_register_o,
  // two-wire ports
  input  wire logic [prf_pkg::TWI_N-1:0]          twi_disable_wr_i,
  input  wire logic [prf_pkg::TWI_N-1:0]          twi_disable_val_i,
  output logic      [prf_pkg::TWI_N-1:0]          twi_module_disable_o,
  output logic      [prf_pkg::TWI_N-1:0]          twi_core_reset_o,
  output logic      [prf_pkg::TWI_N-1:0]          twi_reg_access_ok_o,
  // periodic timers
  input  wire logic [prf_pkg::PIT_N-1:0]          pit_disable_wr_i,
  input  wire logic [prf_pkg::PIT_N-1:0]          pit_disable_val_i,
  input  wire logic [prf_pkg::PIT_N-1:0]          pit_irq_raw_i,
  input  wire logic [prf_pkg::PIT_N-1:0]          pit_dma_raw_i,
  output logic      [prf_pkg::PIT_N-1:0]          pit_module_disable_o,
  output logic      [prf_pkg::PIT_N-1:0]          pit_clock_en_o,
  output logic      [prf_pkg::PIT_N-1:0]          pit_irq_o,
  output logic      [prf_pkg::PIT_N-1:0]          pit_dma_req_o,
  // lin controllers
  input  wire logic [prf_pkg::LIN_N-1:0]          lin_init_wr_i,
  input  wire logic [prf_pkg::LIN_N-1:0]          lin_init_val_i,
  input  wire logic [prf_pkg::LIN_N-1:0]          lin_baud_wr_i,
  input  wire logic [prf_pkg::BAUD_W-1:0]         lin_baud_val_i,
  input  wire logic [prf_pkg::LIN_N-1:0]          lin_tx_raw_i,
  output logic      [prf_pkg::LIN_N-1:0]          lin_control_first_init_o,
  output logic      [prf_pkg::LIN_N*prf_pkg::BAUD_W-1:0] lin_baud_integer_o,
  output logic      [prf_pkg::LIN_N-1:0]          lin_clock_en_o,
  output logic      [prf_pkg::LIN_N-1:0]          lin_bus_active_o,
  output logic      [prf_pkg::LIN_N-1:0]          lin_transmit_output_o,
  // psi5 units
  input  wire logic [prf_pkg::PSI_N-1:0]          psi_gdis_wr_i,
  input  wire logic [prf_pkg::PSI_N-1:0]          psi_gdis_val_i,
  input  wire logic [prf_pkg::PSI_N-1:0]          psi_ch_wr_i,
  input  wire logic [prf_pkg::PSI_CH_N-1:0]       psi_ch_val_i,
  output logic      [prf_pkg::PSI_N-1:0]          psi_global_disable_req_o,
  output logic      [prf_pkg::PSI_N*prf_pkg::PSI_CH_N-1:0] psi_channel_on_o,
  output logic      [prf_pkg::PSI_N-1:0]          psi_counters_run_o,
  // sent units
  input  wire logic [prf_pkg::SENT_N-1:0]         sent_gen_wr_i,
  input  wire logic [prf_pkg::SENT_N-1:0]         sent_gen_val_i,
  input  wire logic [prf_pkg::SENT_N-1:0]         sent_ch_wr_i,
  input  wire logic [prf_pkg::SENT_CH_N-1:0]      sent_ch_val_i,
  output logic      [prf_pkg::SENT_N-1:0]         sent_global_on_o,
  output logic      [prf_pkg::SENT_N*prf_pkg::SENT_CH_N-1:0] sent_channel_on_o,
  // dma channel multiplexer
  input  wire logic                               dmx_ch_wr_i,
  input  wire logic [prf_pkg::DMX_CH_N-1:0]       dmx_ch_val_i,
  input  wire logic [prf_pkg::DMX_CH_N-1:0]       dmx_req_raw_i,
  output logic      [prf_pkg::DMX_CH_N-1:0]       dmx_channel_on_o,
  output logic      [prf_pkg::DMX_CH_N-1:0]       dmx_req_o,
  // time-triggered bus controllers
  input  wire logic [prf_pkg::BC_N-1:0]           bc_on_wr_i,
  input  wire logic [prf_pkg::BC_N-1:0]           bc_on_val_i,
  output logic      [prf_pkg::BC_N-1:0]           bus_controller_on_o,
  // serial inter-processor link
  input  wire logic                               link_on_wr_i,
  input  wire logic                               link_on_val_i,
  input  wire logic                               link_tx_raw_i,
  input  wire logic                               link_rx_raw_i,
  output logic                                    link_module_on_o,
  output logic                                    link_tx_active_o,
  output logic                                    link_rx_active_o,
  // timer module interface
  input  wire logic                               tmi_disable_wr_i,
  input  wire logic                               tmi_disable_val_i,
  output logic                                    tmi_module_disable_o,
  output logic                                    tmi_clock_en_o
);
  import prf_pkg::*;

  // synchronised reset requests; the first stage is read only by the second
  logic [CORE_N-1:0] core_s1;
  logic [CORE_N-1:0] core_s2;
  logic [PRST_W-1:0] prst_s1;
  logic [PRST_W-1:0] prst;

  // reset requests come from another block's registers on an unknown timing
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_s1 <= '0;
      core_s2 <= '0;
      prst_s1 <= '0;
      prst    <= '0;
    end else begin
      core_s1 <= core_reset_vector_i;
      core_s2 <= core_s1;
      prst_s1 <= peripheral_reset_bits_i;
      prst    <= prst_s1;
    end
  end

  // core resets pass straight, one line per core
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_reset_o             <= '0;
      lockstep_compare_event_o <= 1'b0;
    end else begin
      core_reset_o             <= core_s2;
      // the checker event fires without software help when the safety core, the checker core or both are in reset
      lockstep_compare_event_o <= core_s2[CORE_SAFETY] ^ core_s2[CORE_CHECKER] |
                                  core_s2[CORE_SAFETY] & core_s2[CORE_CHECKER];
    end
  end

  // serial peripheral ports
  logic [SPI_N-1:0] spi_dis;
  logic [SPI_N-1:0] spi_halt;
  logic [TCR_W-1:0] spi_tcr [SPI_N];
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spi_dis  <= '0;
      spi_halt <= '1;
      for (int i = 0; i < SPI_N; i++) begin
        spi_tcr[i] <= TCR_RST;
      end
    end else begin
      for (int i = 0; i < SPI_N; i++) begin
        if (prst[SPI_IDX[i]]) begin
          spi_dis[i]  <= 1'b0;
          spi_halt[i] <= 1'b1;
          spi_tcr[i]  <= TCR_RST;
        end else begin
          if (spi_disable_wr_i[i]) spi_dis[i] <= spi_disable_val_i[i];
          if (spi_halt_wr_i[i]) spi_halt[i] <= spi_halt_val_i[i];
          if (spi_frame_done_i[i] && !spi_dis[i] && !spi_halt[i]) spi_tcr[i] <= spi_tcr[i] + 1'b1;
        end
      end
    end
  end
  always_comb begin
    spi_module_disable_o = spi_dis;
    spi_halt_o           = spi_halt;
    spi_run_o            = ~spi_dis & ~spi_halt;
    for (int i = 0; i < SPI_N; i++) begin
      transfer_count_register_o[i*TCR_W +: TCR_W] = spi_tcr[i];
    end
  end

  // two-wire ports: disable holds the interface, not the register file
  logic [TWI_N-1:0] twi_dis;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      twi_dis <= '1;
    end else begin
      for (int i = 0; i < TWI_N; i++) begin
        if (prst[TWI_IDX[i]]) twi_dis[i] <= 1'b1;
        else if (twi_disable_wr_i[i]) twi_dis[i] <= twi_disable_val_i[i];
      end
    end
  end
  assign twi_module_disable_o = twi_dis;
  assign twi_core_reset_o     = twi_dis;
  // register file sits outside the disable, so software access is never refused
  assign twi_reg_access_ok_o  = {TWI_N{1'b1}};

  // periodic timers: disable gates the clock, so no events leave
  logic [PIT_N-1:0] pit_dis;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pit_dis <= '1;
    end else begin
      for (int i = 0; i < PIT_N; i++) begin
        if (prst[PIT_IDX[i]]) pit_dis[i] <= 1'b1;
        else if (pit_disable_wr_i[i]) pit_dis[i] <= pit_disable_val_i[i];
      end
    end
  end
  assign pit_module_disable_o = pit_dis;
  // combinational gating blocks events from the first disabled cycle
  assign pit_clock_en_o       = ~pit_dis;
  assign pit_irq_o            = pit_irq_raw_i & ~pit_dis;
  assign pit_dma_req_o        = pit_dma_raw_i & ~pit_dis;

  // lin controllers: no enable bit, zero divisor keeps the lin clock off
  logic [LIN_N-1:0]  lin_init;
  logic [BAUD_W-1:0] lin_baud [LIN_N];
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lin_init <= '0;
      for (int i = 0; i < LIN_N; i++) begin
        lin_baud[i] <= BAUD_RST;
      end
    end else begin
      for (int i = 0; i < LIN_N; i++) begin
        if (prst[LIN_IDX[i]]) begin
          lin_init[i] <= 1'b0;
          lin_baud[i] <= BAUD_RST;
        end else begin
          if (lin_init_wr_i[i]) lin_init[i] <= lin_init_val_i[i];
          if (lin_baud_wr_i[i]) lin_baud[i] <= lin_baud_val_i;
        end
      end
    end
  end
  // transmit pin is a data output, so it is registered
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lin_transmit_output_o <= {LIN_N{LIN_TX_RECESSIVE}};
    end else begin
      for (int i = 0; i < LIN_N; i++) begin
        lin_transmit_output_o[i] <= lin_init[i] || prst[LIN_IDX[i]] ? LIN_TX_RECESSIVE : lin_tx_raw_i[i];
      end
    end
  end
  always_comb begin
    for (int i = 0; i < LIN_N; i++) begin
      lin_baud_integer_o[i*BAUD_W +: BAUD_W] = lin_baud[i];
      lin_clock_en_o[i]   = |lin_baud[i];
      lin_bus_active_o[i] = !lin_init[i] && (|lin_baud[i]);
    end
  end
  assign lin_control_first_init_o = lin_init;

  // psi5 units
  logic [PSI_N-1:0]    psi_gdis;
  logic [PSI_CH_N-1:0] psi_ch [PSI_N];
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      psi_gdis <= '1;
      for (int i = 0; i < PSI_N; i++) begin
        psi_ch[i] <= '0;
      end
    end else begin
      for (int i = 0; i < PSI_N; i++) begin
        if (prst[PSI_IDX[i]]) begin
          psi_gdis[i] <= 1'b1;
          psi_ch[i]   <= '0;
        end else begin
          if (psi_gdis_wr_i[i]) psi_gdis[i] <= psi_gdis_val_i[i];
          if (psi_ch_wr_i[i]) psi_ch[i] <= psi_ch_val_i;
        end
      end
    end
  end
  always_comb begin
    for (int i = 0; i < PSI_N; i++) begin
      psi_channel_on_o[i*PSI_CH_N +: PSI_CH_N] = psi_ch[i];
    end
  end
  assign psi_global_disable_req_o = psi_gdis;
  assign psi_counters_run_o       = ~psi_gdis;

  // sent units; parameter setup before enabling is left to software
  logic [SENT_N-1:0]    sent_gen;
  logic [SENT_CH_N-1:0] sent_ch [SENT_N];
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sent_gen <= '0;
      for (int i = 0; i < SENT_N; i++) begin
        sent_ch[i] <= '0;
      end
    end else begin
      for (int i = 0; i < SENT_N; i++) begin
        if (prst[SENT_IDX[i]]) begin
          sent_gen[i] <= 1'b0;
          sent_ch[i]  <= '0;
        end else begin
          if (sent_gen_wr_i[i]) sent_gen[i] <= sent_gen_val_i[i];
          if (sent_ch_wr_i[i]) sent_ch[i] <= sent_ch_val_i;
        end
      end
    end
  end
  always_comb begin
    for (int i = 0; i < SENT_N; i++) begin
      sent_channel_on_o[i*SENT_CH_N +: SENT_CH_N] = sent_ch[i];
    end
  end
  assign sent_global_on_o = sent_gen;

  // dma channel multiplexer
  logic [DMX_CH_N-1:0] dmx_ch;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dmx_ch <= '0;
    end else if (prst[DMX_IDX]) begin
      dmx_ch <= '0;
    end else if (dmx_ch_wr_i) begin
      dmx_ch <= dmx_ch_val_i;
    end
  end
  assign dmx_channel_on_o = dmx_ch;
  // requests pass only for enabled channels, so a reset stops transfers from the edge that clears dmx_ch
  assign dmx_req_o        = dmx_req_raw_i & dmx_ch;

  // bus controllers: enable is sticky, only the reset line clears it
  logic [BC_N-1:0] bc_on;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bc_on <= '0;
    end else begin
      for (int i = 0; i < BC_N; i++) begin
        if (prst[BC_IDX[i]]) bc_on[i] <= 1'b0;
        else if (bc_on_wr_i[i] && bc_on_val_i[i]) bc_on[i] <= 1'b1;
      end
    end
  end
  assign bus_controller_on_o = bc_on;

  // inter-processor link: activity gated at once by the reset line too
  logic link_on;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_on <= 1'b0;
    end else if (prst[LINK_IDX]) begin
      link_on <= 1'b0;
    end else if (link_on_wr_i) begin
      link_on <= link_on_val_i;
    end
  end
  assign link_module_on_o = link_on;
  assign link_tx_active_o = link_tx_raw_i & link_on & ~prst[LINK_IDX];
  assign link_rx_active_o = link_rx_raw_i & link_on & ~prst[LINK_IDX];

  // timer module interface: clock gate only, state frozen not cleared
  logic tmi_dis;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmi_dis <= 1'b1;
    end else if (prst[TMI_IDX]) begin
      tmi_dis <= 1'b1;
    end else if (tmi_disable_wr_i) begin
      tmi_dis <= tmi_disable_val_i;
    end
  end
  assign tmi_module_disable_o = tmi_dis;
  assign tmi_clock_en_o       = ~tmi_dis;
endmodule : prf_fanout

// *** tb/prf_fanout_assertions.sv ***
// assertion checker on the reset fanout ports
`timescale 1ns/1ps
module prf_fanout_chk (
  input wire logic         clock_i,
  input wire logic         rst_n_i,
  input wire logic [255:0] peripheral_reset_bits_i,
  input wire logic [1:0]   bc_on_wr_i,
  input wire logic [1:0]   bc_on_val_i,
  input wire logic [1:0]   bus_controller_on_o,
  input wire logic [7:0]   spi_module_disable_o,
  input wire logic [7:0]   spi_halt_o,
  input wire logic [7:0]   spi_run_o,
  input wire logic [127:0] transfer_count_register_o,
  input wire logic [1:0]   twi_module_disable_o,
  input wire logic [1:0]   twi_core_reset_o,
  input wire logic [1:0]   pit_module_disable_o,
  input wire logic [1:0]   pit_irq_o,
  input wire logic [1:0]   pit_dma_req_o,
  input wire logic [5:0]   lin_control_first_init_o,
  input wire logic [5:0]   lin_transmit_output_o,
  input wire logic [119:0] lin_baud_integer_o,
  input wire logic [5:0]   lin_clock_en_o,
  input wire logic         link_tx_active_o,
  input wire logic         link_rx_active_o
);
  // single clock domain, so one default clock and disable
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // reset lines of the first serial port, two-wire port, bus controller and link
  wire r99  = peripheral_reset_bits_i[99];
  wire r101 = peripheral_reset_bits_i[101];
  wire r107 = peripheral_reset_bits_i[107];
  wire r11  = peripheral_reset_bits_i[11];
  // reset reaches unit state three edges after the bit is sampled
  a_bc_reset_clear: assert property (r107 [*3] |=> !bus_controller_on_o[0])
    else $error("bus controller still on after its reset");
  // a write is only safe to judge with no reset in the sync stages
  a_bc_write_one: assert property (bc_on_wr_i[0] && bc_on_val_i[0] && !r107 && !$past(r107)
    && !$past(r107, 2) && !$past(r107, 3) |=> bus_controller_on_o[0])
    else $error("bus controller not enabled by write of one");
  a_bc_stays_on: assert property (bus_controller_on_o[0] && !$past(r107, 2) |=> bus_controller_on_o[0])
    else $error("bus controller left enabled state");
  a_spi_reset_state: assert property (r99 [*3] |=> spi_halt_o[0] && !spi_module_disable_o[0]
    && transfer_count_register_o[15:0] == 16'h0000)
    else $error("serial port wrong state after its reset");
  a_spi_count_hold: assert property (!spi_run_o[0] && !$past(r99, 2)
    |=> $stable(transfer_count_register_o[15:0]))
    else $error("transfer count moved while halted");
  a_twi_reset_hold: assert property (r101 [*3] |=> twi_module_disable_o[0] && twi_core_reset_o[0])
    else $error("two-wire port not disabled after its reset");
  a_pit_gate_out: assert property (pit_module_disable_o[0] |-> !pit_irq_o[0] && !pit_dma_req_o[0])
    else $error("disabled timer raised a request");
  a_lin_init_tx: assert property (lin_control_first_init_o[0] && $past(lin_control_first_init_o[0])
    |-> lin_transmit_output_o[0])
    else $error("lin transmit not recessive in init mode");
  a_lin_baud_clock: assert property (lin_clock_en_o[0] == (lin_baud_integer_o[19:0] != 20'h0_0000))
    else $error("lin clock enable disagrees with divisor");
  a_link_stop_now: assert property (r11 ##1 r11 |=> !link_tx_active_o && !link_rx_active_o)
    else $error("link activity after its reset");
  c_bc_reset: cover property (bus_controller_on_o[0] ##1 r107 [*3] ##1 !bus_controller_on_o[0]);
  c_lin_init: cover property (lin_control_first_init_o[0] [*2]);
  c_spi_halt: cover property (spi_run_o[0] ##1 !spi_run_o[0]);
endmodule : prf_fanout_chk
bind prf_fanout prf_fanout_chk u_prf_fanout_chk (.*);

// *** tb/prf_rst_src.sv ***
// behavioural reset source standing in for reset generation and mode entry
`timescale 1ns/1ps
module prf_rst_src #(
  parameter int HOLD = 4
) (
  input  wire logic         clock_i,
  input  wire logic         go_i,
  input  wire logic [7:0]   idx_i,
  input  wire logic [4:0]   core_i,
  output logic      [4:0]   core_reset_vector_o,
  output logic      [255:0] peripheral_reset_bits_o
);
  int           cnt  = 0;
  logic [4:0]   core = '0;
  logic [255:0] bits = '0;
  // one bit at a time, held long enough to pass both sync stages
  always @(posedge clock_i) begin
    cnt  <= go_i ? HOLD : (cnt != 0 ? cnt - 1 : 0);
    bits <= (go_i || cnt > 1) ? (256'h1 << idx_i) : '0;
    core <= core_i;
  end
  assign core_reset_vector_o     = core;
  assign peripheral_reset_bits_o = bits;
endmodule : prf_rst_src

// *** tb/prf_fanout_tb_top.sv ***
// self-checking bench for the reset fanout
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module prf_fanout_tb_top;
  import prf_pkg::*;
  int checks = 0, n_mismatch = 0;
  logic clock_i = 1'b0, rst_n_i = 1'b0, pgo = 1'b0, lockstep_compare_event_o;
  logic [7:0] pidx = 8'h00;
  logic [CORE_N-1:0] core_set = '0, core_reset_vector_i, core_reset_o;
  logic [PRST_W-1:0] peripheral_reset_bits_i;
  logic [SPI_N-1:0] spi_disable_wr_i = '0, spi_disable_val_i = '0, spi_halt_wr_i = '0, spi_halt_val_i = '0;
  logic [SPI_N-1:0] spi_frame_done_i = '0, spi_module_disable_o, spi_halt_o, spi_run_o;
  logic [SPI_N*TCR_W-1:0] transfer_count_register_o;
  logic [TWI_N-1:0] twi_disable_wr_i = '0, twi_disable_val_i = '0;
  logic [TWI_N-1:0] twi_module_disable_o, twi_core_reset_o, twi_reg_access_ok_o;
  logic [PIT_N-1:0] pit_disable_wr_i = '0, pit_disable_val_i = '0, pit_irq_raw_i = '1, pit_dma_raw_i = '1;
  logic [PIT_N-1:0] pit_module_disable_o, pit_clock_en_o, pit_irq_o, pit_dma_req_o;
  logic [LIN_N-1:0] lin_init_wr_i = '0, lin_init_val_i = '0, lin_baud_wr_i = '0, lin_tx_raw_i = '0;
  logic [LIN_N-1:0] lin_control_first_init_o, lin_clock_en_o, lin_bus_active_o, lin_transmit_output_o;
  logic [BAUD_W-1:0] lin_baud_val_i = '0;
  logic [LIN_N*BAUD_W-1:0] lin_baud_integer_o;
  logic [PSI_N-1:0] psi_gdis_wr_i = '0, psi_gdis_val_i = '0, psi_ch_wr_i = '0;
  logic [PSI_N-1:0] psi_global_disable_req_o, psi_counters_run_o;
  logic [PSI_CH_N-1:0] psi_ch_val_i = '0;
  logic [PSI_N*PSI_CH_N-1:0] psi_channel_on_o;
  logic [SENT_N-1:0] sent_gen_wr_i = '0, sent_gen_val_i = '0, sent_ch_wr_i = '0, sent_global_on_o;
  logic [SENT_CH_N-1:0] sent_ch_val_i = '0;
  logic [SENT_N*SENT_CH_N-1:0] sent_channel_on_o;
  logic dmx_ch_wr_i = 1'b0, link_on_wr_i = 1'b0, link_on_val_i = 1'b0, link_tx_raw_i = 1'b1, link_rx_raw_i = 1'b1;
  logic [DMX_CH_N-1:0] dmx_ch_val_i = '0, dmx_req_raw_i = '1, dmx_channel_on_o, dmx_req_o;
  logic [BC_N-1:0] bc_on_wr_i = '0, bc_on_val_i = '0, bus_controller_on_o;
  logic link_module_on_o, link_tx_active_o, link_rx_active_o, tmi_disable_wr_i = 1'b0, tmi_disable_val_i = 1'b0;
  logic tmi_module_disable_o, tmi_clock_en_o;
  prf_fanout u_prf_fanout (.*);
  prf_rst_src u_prf_rst_src (.clock_i(clock_i), .go_i(pgo), .idx_i(pidx), .core_i(core_set),
    .core_reset_vector_o(core_reset_vector_i), .peripheral_reset_bits_o(peripheral_reset_bits_i));
  initial forever #4 clock_i = ~clock_i;
  // strobes high for exactly one taken edge, then settle one more
  task idle;
    @(posedge clock_i);
    {spi_disable_wr_i, spi_halt_wr_i, twi_disable_wr_i, pit_disable_wr_i, lin_init_wr_i, lin_baud_wr_i, psi_gdis_wr_i,
     psi_ch_wr_i, sent_gen_wr_i, sent_ch_wr_i, dmx_ch_wr_i, bc_on_wr_i, link_on_wr_i, tmi_disable_wr_i} <= '0;
    @(posedge clock_i);
    #1;
  endtask : idle
  // software brings every unit out of its post-reset state
  task en_all;
    @(posedge clock_i);
    {spi_disable_wr_i, spi_halt_wr_i, twi_disable_wr_i, pit_disable_wr_i, lin_init_wr_i, lin_baud_wr_i, psi_gdis_wr_i,
     psi_ch_wr_i, sent_gen_wr_i, sent_ch_wr_i, dmx_ch_wr_i, bc_on_wr_i, link_on_wr_i, tmi_disable_wr_i} <= '1;
    {spi_disable_val_i, spi_halt_val_i, twi_disable_val_i, pit_disable_val_i, psi_gdis_val_i, tmi_disable_val_i,
     lin_init_val_i} <= '0;
    {psi_ch_val_i, sent_gen_val_i, sent_ch_val_i, dmx_ch_val_i, bc_on_val_i, link_on_val_i} <= '1;
    lin_baud_val_i <= 20'h0_0005;
    idle();
  endtask : en_all
  // fire one peripheral reset bit; waits past sync plus update
  task go(input int idx);
    @(posedge clock_i);
    pidx <= idx[7:0];
    pgo <= 1'b1;
    @(posedge clock_i);
    pgo <= 1'b0;
    repeat (8) @(posedge clock_i);
    #1;
  endtask : go
  task chk_rst;
    `CHK("ones", '1, {spi_halt_o, twi_module_disable_o, twi_core_reset_o})
    `CHK("dis", '1, {pit_module_disable_o, tmi_module_disable_o})
    `CHK("regs", '1, {twi_reg_access_ok_o, psi_global_disable_req_o})
    `CHK("spi", '0, {spi_module_disable_o, transfer_count_register_o})
    `CHK("lin", '0, {lin_control_first_init_o, lin_baud_integer_o, lin_clock_en_o})
    `CHK("gated", '0, {pit_irq_o, pit_dma_req_o, tmi_clock_en_o, psi_counters_run_o})
    `CHK("psi_sent", '0, {psi_channel_on_o, sent_global_on_o, sent_channel_on_o})
    `CHK("dmx_bc", '0, {dmx_channel_on_o, dmx_req_o, bus_controller_on_o})
    `CHK("link", '0, {link_module_on_o, link_tx_active_o, link_rx_active_o})
  endtask : chk_rst
  task results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  initial begin
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    #1;
    chk_rst();
    for (int i = 0; i < CORE_N; i++) begin
      core_set <= 5'h01 << i;
      repeat (5) @(posedge clock_i);
      #1;
      `CHK("core", 5'h01 << i, core_reset_o)
      `CHK("lockstep", i == CORE_SAFETY || i == CORE_CHECKER, lockstep_compare_event_o)
    end
    core_set <= '0;
    // enabling is the last step of setup; these ports carry no sent or bus controller parameters
    en_all();
    `CHK("off", '0, {spi_module_disable_o, spi_halt_o, twi_module_disable_o, twi_core_reset_o})
    `CHK("dis_off", '0, {pit_module_disable_o, tmi_module_disable_o, psi_global_disable_req_o})
    `CHK("lin_off", '0, {lin_control_first_init_o, lin_transmit_output_o})
    `CHK("baud", {LIN_N{20'h0_0005}}, lin_baud_integer_o)
    `CHK("on", '1, {spi_run_o, pit_irq_o, lin_clock_en_o, psi_channel_on_o, sent_channel_on_o, dmx_req_o})
    `CHK("clk_on", '1, {pit_clock_en_o, pit_dma_req_o, tmi_clock_en_o, psi_counters_run_o})
    `CHK("ctl_on", '1, {sent_global_on_o, dmx_channel_on_o, lin_bus_active_o, twi_reg_access_ok_o})
    `CHK("link_on", 3'h7, {link_module_on_o, link_tx_active_o, link_rx_active_o})
    `CHK("bc_on", 2'h3, bus_controller_on_o)
    @(posedge clock_i);
    bc_on_wr_i <= '1;
    bc_on_val_i <= '0;
    idle();
    `CHK("bc_keep", 2'h3, bus_controller_on_o)
    @(posedge clock_i);
    spi_frame_done_i <= 8'h01;
    repeat (3) @(posedge clock_i);
    spi_frame_done_i <= 8'h00;
    idle();
    `CHK("tcr", 16'h0003, transfer_count_register_o[15:0])
    go(SPI_IDX[0]);
    `CHK("spi_one", {8'h01, 8'hfe}, {spi_halt_o, spi_run_o})
    `CHK("tcr_zero", 16'h0000, transfer_count_register_o[15:0])
    @(posedge clock_i);
    lin_init_wr_i <= 6'h01;
    lin_init_val_i <= 6'h3f;
    idle();
    `CHK("lin_init", 3'h6, {lin_control_first_init_o[0], lin_transmit_output_o[0], lin_bus_active_o[0]})
    go(LIN_IDX[0]);
    `CHK("lin_one", {6'h00, 6'h3e}, {lin_control_first_init_o, lin_clock_en_o})
    for (int i = 0; i < SPI_N; i++) go(SPI_IDX[i]);
    for (int i = 0; i < TWI_N; i++) go(TWI_IDX[i]);
    for (int i = 0; i < PIT_N; i++) go(PIT_IDX[i]);
    for (int i = 0; i < LIN_N; i++) go(LIN_IDX[i]);
    for (int i = 0; i < PSI_N; i++) go(PSI_IDX[i]);
    for (int i = 0; i < SENT_N; i++) go(SENT_IDX[i]);
    for (int i = 0; i < BC_N; i++) go(BC_IDX[i]);
    go(DMX_IDX);
    go(LINK_IDX);
    go(TMI_IDX);
    chk_rst();
    results();
  end
  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (3000) @(posedge clock_i);
    n_mismatch++;
    results();
  end
endmodule : prf_fanout_tb_top
